/* sac_pkg.sv */
package sac_pkg;
  // ------------------------------------------------------------
  // conversion timing, in conversion-clock periods
  // ------------------------------------------------------------
  localparam int unsigned SAC_WIDTH = 8;
  localparam int unsigned SAC_CONV_CYCLES = 64;
  localparam int unsigned SAC_BIT_CYCLES = SAC_CONV_CYCLES / SAC_WIDTH;
  localparam int unsigned SAC_START_ALIGN_MAX = 8;
  localparam int unsigned SAC_DONE_HOLD = 8;
  localparam int unsigned SAC_LATCH_LEAD = 1;
  // ------------------------------------------------------------
  // conversion-clock divider and result codes
  // ------------------------------------------------------------
  localparam int unsigned SAC_CLK_DIV = 4;
  localparam logic [7:0] SAC_RESULT_RST = 8'h00;
  localparam logic [7:0] SAC_ZERO_CODE = 8'h00;

  typedef enum logic [4:0] {
    SAC_IDLE = 5'h01,
    SAC_HOLD = 5'h02,
    SAC_ALIGN = 5'h04,
    SAC_CONV = 5'h08,
    SAC_LATCH = 5'h10
  } sac_state_t;
endpackage : sac_pkg

/* sac_cmp_if.sv */
`timescale 1ns/10ps
interface sac_cmp_if;
  logic [7:0] trial;
  logic above;
  modport ctrl (output trial, input above);
  modport cmp (input trial, output above);
endinterface : sac_cmp_if

/* sac_comparator.sv */
`timescale 1ns/10ps
module sac_comparator
  import sac_pkg::*;
(
  input wire logic [7:0] vin_pos,
  input wire logic [7:0] vin_neg,
  sac_cmp_if.cmp cmp
);
  // ------------------------------------------------------------
  // digital model of ladder compare on the difference
  // ------------------------------------------------------------
  logic [8:0] diff;
  always_comb begin
    // negative difference clamps to zero, so every nonzero trial fails
    if (vin_neg >= vin_pos) begin
      diff = 9'h000;
    end else begin
      diff = {1'b0, vin_pos} - {1'b0, vin_neg};
    end
  end
  assign cmp.above = (diff >= {1'b0, cmp.trial});
endmodule : sac_comparator

/* sac_adc_ctrl.sv */
`timescale 1ns/10ps
module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int unsigned CLK_DIV = SAC_CLK_DIV
)(
  input wire logic clock,
  input wire logic srst,
  input wire logic chip_select_n,
  input wire logic start_n,
  input wire logic read_n,
  input wire logic [7:0] vin_pos,
  input wire logic [7:0] vin_neg,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic conversion_done_n
);
  sac_cmp_if cmp_bus ();
  sac_comparator u_cmp (
    .vin_pos(vin_pos),
    .vin_neg(vin_neg),
    .cmp(cmp_bus)
  );

  // ------------------------------------------------------------
  // conversion-clock enable
  // ------------------------------------------------------------
  logic [7:0] div_cnt;
  logic tick;
  always_ff @(posedge clock) begin
    if (srst || div_cnt == 8'(CLK_DIV - 1)) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign tick = (div_cnt == 8'(CLK_DIV - 1));

  // ------------------------------------------------------------
  // start latch and sequencer
  // ------------------------------------------------------------
  logic start_req;
  logic start_latch;
  logic read_req;
  sac_state_t state;
  logic [7:0] approximation_register;
  logic [7:0] bit_mask;
  logic [2:0] sub_cnt;
  logic [2:0] align_cnt;
  logic [3:0] done_cnt;
  logic done_flag;
  logic [7:0] result;

  assign start_req = !chip_select_n && !start_n;
  assign read_req = !chip_select_n && !read_n;
  assign cmp_bus.trial = approximation_register | bit_mask;

  // short strobes survive until the phase is right
  always_ff @(posedge clock) begin
    if (srst) begin
      start_latch <= 1'b0;
    end else if (start_req) begin
      start_latch <= 1'b1;
    end else if (tick && state == SAC_ALIGN) begin
      start_latch <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= SAC_IDLE;
      approximation_register <= 8'h00;
      bit_mask <= 8'h80;
      sub_cnt <= 3'h0;
      align_cnt <= 3'h0;
    end else if (start_req) begin
      // reset held for as long as the strobe stays low
      state <= SAC_HOLD;
      approximation_register <= 8'h00;
      bit_mask <= 8'h80;
      sub_cnt <= 3'h0;
      align_cnt <= 3'h0;
    end else begin
      case (state)
        SAC_IDLE: begin
          state <= SAC_IDLE;
        end
        SAC_HOLD: begin
          state <= SAC_ALIGN;
        end
        SAC_ALIGN: begin
          // waits for a conversion-clock phase, at most 8 periods
          if (tick) begin
            align_cnt <= align_cnt + 3'h1;
            if (align_cnt == 3'(SAC_START_ALIGN_MAX - 1) || start_latch) begin
              state <= SAC_CONV;
            end
          end
        end
        SAC_CONV: begin
          if (tick) begin
            sub_cnt <= sub_cnt + 3'h1;
            if (sub_cnt == 3'(SAC_BIT_CYCLES - 1)) begin
              if (cmp_bus.above) begin
                approximation_register <= cmp_bus.trial;
              end
              bit_mask <= bit_mask >> 1;
              if (bit_mask == 8'h01) begin
                state <= SAC_LATCH;
              end
            end
          end
        end
        SAC_LATCH: begin
          if (tick) begin
            state <= SAC_IDLE;
          end
        end
        default: begin
          state <= SAC_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // output latch and done flag
  // ------------------------------------------------------------
  // result moves when the last bit settles, a period before done
  always_ff @(posedge clock) begin
    if (srst) begin
      result <= SAC_RESULT_RST;
    end else if (state == SAC_CONV && tick && bit_mask == 8'h01 &&
                 sub_cnt == 3'(SAC_BIT_CYCLES - 1)) begin
      result <= cmp_bus.above ? cmp_bus.trial
                              : approximation_register;
    end
  end

  // set pulse outlasts a held read for eight periods
  always_ff @(posedge clock) begin
    if (srst) begin
      done_cnt <= 4'h0;
    end else if (start_req) begin
      done_cnt <= 4'h0;
    end else if (state == SAC_LATCH && tick) begin
      done_cnt <= 4'(SAC_DONE_HOLD);
    end else if (tick && done_cnt != 4'h0) begin
      done_cnt <= done_cnt - 4'h1;
    end
  end

  // free-running power-up: flag starts clear, host must strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      done_flag <= 1'b0;
    end else if (state == SAC_LATCH && tick) begin
      done_flag <= 1'b1; // set wins over read
    end else if (start_req || (read_req && done_cnt == 4'h0)) begin
      // a read inside the set window cannot clear the flag
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      data_out <= 8'h00;
    end else begin
      data_out <= result;
    end
  end

  assign data_oe = read_req;
  assign conversion_done_n = !(done_flag && (!read_req || done_cnt != 4'h0));

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_last_bit;
    state == SAC_CONV && tick && bit_mask == 8'h01 &&
      sub_cnt == 3'(SAC_BIT_CYCLES - 1);
  endsequence

  // repeat count matches the default divider of four clocks only
  sequence s_latch_wait;
    (state == SAC_LATCH && !start_req && conversion_done_n) [*4];
  endsequence

  property p_zero_code;
    @(posedge clock) disable iff (srst)
      (vin_neg >= vin_pos) |-> !cmp_bus.above || cmp_bus.trial == 8'h00;
  endproperty
  a_zero_code: assert property (p_zero_code)
    else $error("negative difference compares above");

  property p_hold_reset;
    @(posedge clock) disable iff (srst)
      start_req |=> state == SAC_HOLD;
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("held start did not keep reset");

  property p_rise_start;
    @(posedge clock) disable iff (srst)
      $fell(start_req) |-> state == SAC_HOLD ##1 state == SAC_ALIGN;
  endproperty
  a_rise_start: assert property (p_rise_start)
    else $error("start not on rising edge");

  property p_align_bound;
    @(posedge clock) disable iff (srst)
      (state == SAC_ALIGN && !start_req) |-> ##[0:40]
        (state != SAC_ALIGN);
  endproperty
  a_align_bound: assert property (p_align_bound)
    else $error("start alignment too long");

  property p_latch_set;
    @(posedge clock) disable iff (srst)
      start_req |=> start_latch;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("start latch missed request");

  property p_result_lead;
    @(posedge clock) disable iff (srst)
      s_last_bit ##1 s_latch_wait |=> !conversion_done_n;
  endproperty
  a_result_lead: assert property (p_result_lead)
    else $error("done not one period after result");

  property p_read_clear;
    @(posedge clock) disable iff (srst)
      (read_req && done_cnt == 4'h0 && !(state == SAC_LATCH && tick))
        |=> !done_flag;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not clear done");

  property p_done_hold;
    @(posedge clock) disable iff (srst)
      (state == SAC_LATCH && tick && !start_req) |=> done_cnt == 4'h8;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done hold count wrong");

  property p_msb_first;
    @(posedge clock) disable iff (srst)
      (state == SAC_ALIGN) |-> bit_mask == 8'h80;
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("conversion not msb first");

  property p_restart;
    @(posedge clock) disable iff (srst)
      (state == SAC_CONV && start_req) |=>
        approximation_register == 8'h00 && bit_mask == 8'h80;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear sequence");
endmodule : sac_adc_ctrl

/* sac_host_model.sv */
`timescale 1ns/10ps
module sac_host_model (
  input wire logic clock,
  output logic chip_select_n,
  output logic start_n,
  output logic read_n
);
  initial begin
    chip_select_n = 1'b1;
    start_n = 1'b1;
    read_n = 1'b1;
  end

  task automatic set_lines(input logic cs, input logic rd);
    @(posedge clock);
    #1;
    chip_select_n = cs;
    read_n = rd;
  endtask : set_lines

  // select stays low after the strobe when a read is held open
  task automatic start_pulse(input int width);
    set_lines(1'b0, read_n);
    @(posedge clock);
    #1 start_n = 1'b0;
    repeat (width) @(posedge clock);
    #1 start_n = 1'b1;
    set_lines(read_n, read_n);
  endtask : start_pulse

  task automatic read_late(input int wait_clk);
    repeat (wait_clk) @(posedge clock);
    set_lines(1'b0, 1'b0);
  endtask : read_late
endmodule : sac_host_model

/* test_sac_adc_ctrl.sv */
`timescale 1ns/10ps
module test_sac_adc_ctrl;
  import sac_pkg::*;
  localparam int DIV = 4;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] vin_pos, vin_neg, data_out;
  logic data_oe, done_n, cs_n, st_n, rd_n;
  int err_count = 0;
  int n_tests = 0;
  int st_low = 0;
  int hold_bad = 0;
  int exp_q[$];
  logic [15:0] tbl [5] = '{16'hC832, 16'h32C8, 16'h5A5A, 16'hFF00, 16'h0100};

  always #2 clock = ~clock;

  sac_adc_ctrl #(.CLK_DIV(DIV)) i_sac_adc_ctrl (.clock(clock), .srst(srst),
    .chip_select_n(cs_n), .start_n(st_n), .read_n(rd_n), .vin_pos(vin_pos),
    .vin_neg(vin_neg), .data_out(data_out), .data_oe(data_oe),
    .conversion_done_n(done_n));
  sac_host_model i_sac_host_model (.clock(clock), .chip_select_n(cs_n),
    .start_n(st_n), .read_n(rd_n));

  // a strobe held low must keep done released
  always @(posedge clock) begin
    st_low <= st_n ? 0 : st_low + 1;
    if (st_low > 2 && done_n === 1'b0) hold_bad <= hold_bad + 1;
  end

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic wait_done(output int cyc, output logic [7:0] prev);
    cyc = 0;
    prev = data_out;
    while (done_n !== 1'b0) begin
      prev = data_out;
      @(posedge clock);
      #1 cyc++;
      if (cyc > 1000) begin
        err_count++;
        final_report();
      end
    end
  endtask : wait_done

  task automatic convert(input logic [7:0] a, input logic [7:0] b, int w);
    int cyc;
    int exp;
    logic [7:0] prev;
    vin_pos = a;
    vin_neg = b;
    exp_q.push_back(a > b ? a - b : 0);
    i_sac_host_model.start_pulse(w);
    wait_done(cyc, prev);
    exp = exp_q.pop_front();
    check(cyc >= 63 * DIV && cyc <= 74 * DIV, 1);
    check(prev, exp);
    check(data_out, exp);
    if (rd_n === 1'b1) begin
      i_sac_host_model.read_late(8 * DIV);
      @(posedge clock);
      #1 check({data_oe, done_n}, 2'b11);
      i_sac_host_model.set_lines(1'b1, 1'b1);
      @(posedge clock);
      #1 check(done_n, 1'b1);
    end
  endtask : convert

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int cnt;
    void'($urandom(99));
    vin_pos = 8'h00;
    vin_neg = 8'h00;
    repeat (20) @(posedge clock);
    #1 srst = 1'b0;
    check({done_n, data_oe, data_out}, 10'h200);
    convert(8'h40, 8'h10, 1);
    foreach (tbl[i]) convert(tbl[i][15:8], tbl[i][7:0], 1);
    repeat (6) convert(8'($urandom), 8'($urandom), 1 + $urandom % 4);
    convert(8'h77, 8'h07, 400);
    // abandoned run: its code must never appear
    vin_pos = 8'h64;
    vin_neg = 8'h14;
    i_sac_host_model.start_pulse(1);
    repeat (20 * DIV) @(posedge clock);
    convert(8'hE6, 8'h1E, 2);
    i_sac_host_model.set_lines(1'b0, 1'b0);
    convert(8'h90, 8'h10, 1);
    cnt = 0;
    while (done_n === 1'b0 && cnt < 100) begin
      @(posedge clock);
      #1 cnt++;
    end
    check(cnt >= 8 * DIV && cnt <= 8 * DIV + 1, 1);
    check(data_oe, 1'b1);
    i_sac_host_model.set_lines(1'b1, 1'b0);
    @(posedge clock);
    #1 check(data_oe, 1'b0);
    check(done_n, 1'b1);
    check(hold_bad, 0);
    final_report();
  end
endmodule : test_sac_adc_ctrl
